// ### include/dot_mac_map.vh
// Opcode fields, operation codes and reset values of the dot-product unit
`ifndef DOT_MAC_MAP_VH
`define DOT_MAC_MAP_VH

// Instruction word field positions
`define MAJOR_HI 31
`define MAJOR_LO 26
`define SECOND_HI 25
`define SECOND_LO 21
`define FIRST_HI 20
`define FIRST_LO 16
`define ACC_SEL_HI 15
`define ACC_SEL_LO 14
`define EXT_HI 13
`define EXT_LO 6
`define MINOR_HI 5
`define MINOR_LO 0

// Group codes
`define MAJOR_OPCODE_GROUP 6'h00
`define MINOR_OPCODE_GROUP 6'h3c

// Extension codes
`define EXT_UNSIGNED_UPPER 8'h82
`define EXT_UNSIGNED_LOWER 8'hc2
`define EXT_CROSS_HALF 8'h42
`define EXT_SUB_HALF 8'h12

// Reset values
`define ACC_WORD_RESET 32'h00000000
`define OUFLAG_RESET 4'h0

`endif

// ### hdl/dot_product_mac_unit.v
// Dot-product multiply-accumulate datapath with four accumulators
`timescale 1ns/1ps
`include "dot_mac_map.vh"

module dot_product_mac_unit #(
    parameter ACC_COUNT = 4,
    parameter SEL_W = 2
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Instruction issue
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [31:0] first_source_reg,
    input wire [31:0] second_source_reg,
    // Extension state
    input wire ext_present,
    input wire ext_enabled,
    // Accumulator write port
    input wire acc_wr_en,
    input wire [SEL_W-1:0] acc_wr_sel,
    input wire [31:0] acc_wr_high,
    input wire [31:0] acc_wr_low,
    // Accumulator read port
    input wire [SEL_W-1:0] acc_rd_sel,
    output reg [31:0] acc_rd_high_r,
    output reg [31:0] acc_rd_low_r,
    // Overflow flag field port
    input wire ouflag_wr_en,
    input wire [3:0] ouflag_wr_data,
    output reg [3:0] ouflag_r,
    // Completion and faults
    output reg done_r,
    output reg reserved_exc_r,
    output reg disabled_exc_r,
    output reg [31:0] result_high_r,
    output reg [31:0] result_low_r
);

    // Unsigned byte product, 16 bits
    function [15:0] mul_u8;
        input [7:0] a;
        input [7:0] b;
        begin
            mul_u8 = a * b;
        end
    endfunction

    // Signed halfword product, 32 bits
    function [31:0] mul_s16;
        input [15:0] a;
        input [15:0] b;
        reg signed [31:0] sa;
        reg signed [31:0] sb;
        begin
            sa = {{16{a[15]}}, a};
            sb = {{16{b[15]}}, b};
            mul_s16 = sa * sb;
        end
    endfunction

    // Sign-extended sum of two word products
    function [63:0] sum_s32;
        input [31:0] p;
        input [31:0] q;
        reg [32:0] s;
        begin
            s = {p[31], p} + {q[31], q};
            sum_s32 = {{31{s[32]}}, s};
        end
    endfunction

    // Accumulator storage
    reg [31:0] acc_high_word [0:ACC_COUNT-1];
    reg [31:0] acc_low_word [0:ACC_COUNT-1];

    // Instruction fields
    wire [5:0] major_opcode_group;
    wire [5:0] minor_opcode_group;
    wire [7:0] ext_code;
    wire [SEL_W-1:0] accumulator_select;
    assign major_opcode_group = instr_word[`MAJOR_HI:`MAJOR_LO];
    assign minor_opcode_group = instr_word[`MINOR_HI:`MINOR_LO];
    assign ext_code = instr_word[`EXT_HI:`EXT_LO];
    assign accumulator_select =
        instr_word[`ACC_SEL_HI:`ACC_SEL_LO];

    // Operation decode
    wire group_hit;
    wire dot_acc_unsigned_upper_bytes;
    wire dot_acc_unsigned_lower_bytes;
    wire cross_dot_acc_halfwords;
    wire dot_sub_halfwords;
    wire op_claim;
    assign group_hit = instr_valid &&
        (major_opcode_group == `MAJOR_OPCODE_GROUP) &&
        (minor_opcode_group == `MINOR_OPCODE_GROUP);
    assign dot_acc_unsigned_upper_bytes =
        (ext_code == `EXT_UNSIGNED_UPPER);
    assign dot_acc_unsigned_lower_bytes =
        (ext_code == `EXT_UNSIGNED_LOWER);
    assign cross_dot_acc_halfwords =
        (ext_code == `EXT_CROSS_HALF);
    assign dot_sub_halfwords =
        (ext_code == `EXT_SUB_HALF);
    assign op_claim = group_hit &&
        (dot_acc_unsigned_upper_bytes ||
         dot_acc_unsigned_lower_bytes ||
         cross_dot_acc_halfwords ||
         dot_sub_halfwords);

    // Fault classification
    wire fault_reserved;
    wire fault_disabled;
    wire commit;
    assign fault_reserved = op_claim && !ext_present;
    assign fault_disabled =
        op_claim && ext_present && !ext_enabled;
    assign commit = op_claim && ext_present && ext_enabled;

    // Operand halfword lanes
    wire [15:0] first_upper_half;
    wire [15:0] first_lower_half;
    wire [15:0] second_upper_half;
    wire [15:0] second_lower_half;
    assign first_upper_half = first_source_reg[31:16];
    assign first_lower_half = first_source_reg[15:0];
    assign second_upper_half = second_source_reg[31:16];
    assign second_lower_half = second_source_reg[15:0];

    // Byte lanes of the chosen pair: upper pair or lower pair
    wire [7:0] first_byte_b;
    wire [7:0] first_byte_a;
    wire [7:0] second_byte_b;
    wire [7:0] second_byte_a;
    assign first_byte_b = dot_acc_unsigned_upper_bytes ?
        first_source_reg[31:24] : first_source_reg[15:8];
    assign first_byte_a = dot_acc_unsigned_upper_bytes ?
        first_source_reg[23:16] : first_source_reg[7:0];
    assign second_byte_b = dot_acc_unsigned_upper_bytes ?
        second_source_reg[31:24] : second_source_reg[15:8];
    assign second_byte_a = dot_acc_unsigned_upper_bytes ?
        second_source_reg[23:16] : second_source_reg[7:0];

    // Byte lane products, unsigned
    wire [15:0] byte_prod_b;
    wire [15:0] byte_prod_a;
    assign byte_prod_b = mul_u8(first_byte_b, second_byte_b);
    assign byte_prod_a = mul_u8(first_byte_a, second_byte_a);

    // Halfword products: cross and straight pairing
    wire [31:0] cross_prod_b;
    wire [31:0] cross_prod_a;
    wire [31:0] straight_prod_b;
    wire [31:0] straight_prod_a;
    assign cross_prod_b =
        mul_s16(first_upper_half, second_lower_half);
    assign cross_prod_a =
        mul_s16(first_lower_half, second_upper_half);
    assign straight_prod_b =
        mul_s16(first_upper_half, second_upper_half);
    assign straight_prod_a =
        mul_s16(first_lower_half, second_lower_half);

    // Dot-product terms widened to 64 bits
    wire [63:0] byte_dot;
    wire [63:0] cross_dot;
    wire [63:0] straight_dot;
    assign byte_dot = {48'h000000000000, byte_prod_b} +
        {48'h000000000000, byte_prod_a};
    assign cross_dot = sum_s32(cross_prod_b, cross_prod_a);
    assign straight_dot =
        sum_s32(straight_prod_b, straight_prod_a);

    // Selected accumulator as one 64-bit value
    wire [63:0] acc_cur;
    assign acc_cur = {acc_high_word[accumulator_select],
        acc_low_word[accumulator_select]};

    // Candidate sums; all wrap modulo 2^64 without a trap
    wire [63:0] acc_plus_byte;
    wire [63:0] acc_plus_cross;
    wire [63:0] acc_minus_straight;
    assign acc_plus_byte = acc_cur + byte_dot;
    assign acc_plus_cross = acc_cur + cross_dot;
    assign acc_minus_straight = acc_cur - straight_dot;

    // New accumulator value of the decoded form
    reg [63:0] acc_nxt;
    always @* begin
        acc_nxt = acc_cur;
        if (dot_sub_halfwords) begin
            acc_nxt = acc_minus_straight;
        end else if (cross_dot_acc_halfwords) begin
            acc_nxt = acc_plus_cross;
        end else if (dot_acc_unsigned_upper_bytes ||
            dot_acc_unsigned_lower_bytes) begin
            acc_nxt = acc_plus_byte;
        end
    end

    // Halves of the new value; upper bits to the high word
    wire [31:0] new_high_word;
    wire [31:0] new_low_word;
    assign new_high_word = acc_nxt[63:32];
    assign new_low_word = acc_nxt[31:0];

    // High words; an instruction wins over the write port
    integer i;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < ACC_COUNT; i = i + 1) begin
                acc_high_word[i] <= `ACC_WORD_RESET;
            end
        end else begin
            if (acc_wr_en) begin
                acc_high_word[acc_wr_sel] <= acc_wr_high;
            end
            if (commit) begin
                acc_high_word[accumulator_select] <= new_high_word;
            end
        end
    end

    // Low words; same priority as the high words
    integer j;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (j = 0; j < ACC_COUNT; j = j + 1) begin
                acc_low_word[j] <= `ACC_WORD_RESET;
            end
        end else begin
            if (acc_wr_en) begin
                acc_low_word[acc_wr_sel] <= acc_wr_low;
            end
            if (commit) begin
                acc_low_word[accumulator_select] <= new_low_word;
            end
        end
    end

    // Overflow flags: only the port writes them
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ouflag_r <= `OUFLAG_RESET;
        end else if (ouflag_wr_en) begin
            ouflag_r <= ouflag_wr_data;
        end
    end

    // Answer pulses: exactly one per decoded instruction
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'h0;
            reserved_exc_r <= 1'h0;
            disabled_exc_r <= 1'h0;
        end else begin
            done_r <= commit;
            reserved_exc_r <= fault_reserved;
            disabled_exc_r <= fault_disabled;
        end
    end

    // Result of the last committed instruction
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_high_r <= `ACC_WORD_RESET;
            result_low_r <= `ACC_WORD_RESET;
        end else if (commit) begin
            result_high_r <= new_high_word;
            result_low_r <= new_low_word;
        end
    end

    // Registered read of any accumulator
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_rd_high_r <= `ACC_WORD_RESET;
            acc_rd_low_r <= `ACC_WORD_RESET;
        end else begin
            acc_rd_high_r <= acc_high_word[acc_rd_sel];
            acc_rd_low_r <= acc_low_word[acc_rd_sel];
        end
    end

endmodule

// ### verification/dot_mac_properties.sv
// Port-level checks of the dot-product unit
`timescale 1ns/1ps
module dot_mac_properties (
    // Clock, reset and issue
    input wire ref_clk,
    input wire rst_n,
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire ext_present,
    input wire ext_enabled,
    input wire ouflag_wr_en,
    // Results
    input wire [3:0] ouflag_r,
    input wire done_r,
    input wire reserved_exc_r,
    input wire disabled_exc_r,
    input wire [31:0] result_high_r,
    input wire [31:0] result_low_r
);
    // Recognised word and any answer
    wire [7:0] e = instr_word[13:6];
    wire dec = instr_valid && instr_word[31:26] == 6'h00 &&
        instr_word[5:0] == 6'h3c &&
        (e == 8'h82 || e == 8'hc2 || e == 8'h42 || e == 8'h12);
    wire ans = done_r | reserved_exc_r | disabled_exc_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; dec && ext_present && ext_enabled; endsequence
    sequence s_fault; dec && !(ext_present && ext_enabled); endsequence
    property p_commit; s_take |=> done_r; endproperty
    a_commit: assert property (p_commit) else $error("no commit");
    property p_resv; dec && !ext_present |=> reserved_exc_r; endproperty
    a_resv: assert property (p_resv) else $error("no reserved");
    property p_dis; s_fault ##0 ext_present |=> disabled_exc_r; endproperty
    a_dis: assert property (p_dis) else $error("no disabled");
    property p_ignore; !dec |=> !ans; endproperty
    a_ignore: assert property (p_ignore) else $error("stray");
    property p_one; ans |-> $onehot({done_r, reserved_exc_r,
        disabled_exc_r}); endproperty
    a_one: assert property (p_one) else $error("two answers");
    property p_flag; !ouflag_wr_en |=> $stable(ouflag_r); endproperty
    a_flag: assert property (p_flag) else $error("flag set");
    property p_hold; !done_r |-> $stable({result_high_r, result_low_r});
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_cause; done_r |-> $past(ext_present && ext_enabled);
    endproperty
    a_cause: assert property (p_cause) else $error("bad commit");
endmodule

bind dot_product_mac_unit dot_mac_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_present(ext_present),
    .ext_enabled(ext_enabled), .ouflag_wr_en(ouflag_wr_en),
    .ouflag_r(ouflag_r), .done_r(done_r), .reserved_exc_r(reserved_exc_r),
    .disabled_exc_r(disabled_exc_r), .result_high_r(result_high_r),
    .result_low_r(result_low_r));

// ### verification/pipe_model.sv
// Pipeline model packing issued dot-product words
`timescale 1ns/1ps
module pipe_model (
    // Issue request
    input wire issue,
    input wire [1:0] acc_sel,
    input wire [7:0] ext_code,
    // Word to the unit
    output wire instr_valid,
    output wire [31:0] instr_word
);
    // Group codes frame the fields; idle word flips
    wire [31:0] w = {6'h00, 5'h02, 5'h01, acc_sel, ext_code,
        6'h3c};
    assign instr_word = issue ? w : ~w;
    assign instr_valid = issue;
endmodule

// ### verification/dot_product_mac_unit_tb.sv
// Self-checking bench of the dot-product unit
`timescale 1ns/1ps
module dot_product_mac_unit_tb;
    reg ref_clk = 0, rst_n = 0, issue = 0, acc_wr_en = 0, ouflag_wr_en = 0;
    reg ext_present = 1, ext_enabled = 1;
    reg [1:0] acc_sel = 0, acc_wr_sel = 0, acc_rd_sel = 0;
    reg [7:0] ext_code = 0;
    reg [31:0] s = 0, t = 0, acc_wr_high = 0, acc_wr_low = 0;
    reg [3:0] fw = 0;
    reg [63:0] acc [0:3];
    reg [63:0] last = 0;
    reg [66:0] q [$];
    reg [66:0] seen_note = 0, exp_note = 0;
    reg [7:0] codes [0:4] = '{8'h82, 8'hc2, 8'h42, 8'h12, 8'h00};
    integer miscompares = 0, checked = 0, i, k;
    wire instr_valid, done_r, reserved_exc_r, disabled_exc_r;
    wire [31:0] instr_word, acc_rd_high_r, acc_rd_low_r;
    wire [31:0] result_high_r, result_low_r;
    wire [3:0] ouflag_r;
    always #2 ref_clk = ~ref_clk;
    pipe_model model (.issue(issue), .acc_sel(acc_sel),
        .ext_code(ext_code), .instr_valid(instr_valid),
        .instr_word(instr_word));
    dot_product_mac_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .first_source_reg(s), .second_source_reg(t),
        .ext_present(ext_present), .ext_enabled(ext_enabled),
        .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel),
        .acc_wr_high(acc_wr_high), .acc_wr_low(acc_wr_low),
        .acc_rd_sel(acc_rd_sel), .acc_rd_high_r(acc_rd_high_r),
        .acc_rd_low_r(acc_rd_low_r), .ouflag_wr_en(ouflag_wr_en),
        .ouflag_wr_data(fw), .ouflag_r(ouflag_r), .done_r(done_r),
        .reserved_exc_r(reserved_exc_r), .disabled_exc_r(disabled_exc_r),
        .result_high_r(result_high_r), .result_low_r(result_low_r));
    task check(input [66:0] seen, input [66:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0t %h %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (miscompares == 0 && checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    // Reference accumulate, wrapping modulo 2^64
    function [63:0] f(input [7:0] e, input [31:0] a, b, input [63:0] c);
        reg signed [63:0] p;
        begin
            case (e)
                8'h82: f = c + a[31:24] * b[31:24] +
                    a[23:16] * b[23:16];
                8'hc2: f = c + a[15:8] * b[15:8] +
                    a[7:0] * b[7:0];
                8'h42: begin
                    p = $signed(a[31:16]) * $signed(b[15:0]);
                    p = p + $signed(a[15:0]) * $signed(b[31:16]);
                    f = c + p;
                end
                default: begin
                    p = $signed(a[31:16]) * $signed(b[31:16]);
                    p = p + $signed(a[15:0]) * $signed(b[15:0]);
                    f = c - p;
                end
            endcase
        end
    endfunction
    // Each answer retires the oldest note
    always @(negedge ref_clk) begin
        if ((done_r | reserved_exc_r | disabled_exc_r) === 1'h1) begin
            seen_note = {disabled_exc_r, reserved_exc_r, done_r,
                result_high_r, result_low_r};
            exp_note = q.size() ? q.pop_front() : 67'h0;
            check(seen_note, exp_note);
        end
    end
    // Hang guard
    initial begin
        #20000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end
    // Preload, random issue stream, then read back
    initial begin
        void'($urandom(96));
        repeat (16) @(negedge ref_clk);
        rst_n = 1;
        fw = $urandom;
        acc_wr_en = 1;
        ouflag_wr_en = 1;
        for (i = 0; i < 4; i = i + 1) begin
            acc[i] = {$urandom, $urandom};
            acc_wr_sel = i[1:0];
            {acc_wr_high, acc_wr_low} = acc[i];
            @(negedge ref_clk);
        end
        acc_wr_en = 0;
        ouflag_wr_en = 0;
        for (k = 0; k < 400; k = k + 1) begin
            i = $urandom % 5;
            acc_sel = $urandom;
            acc_rd_sel = $urandom;
            s = $urandom;
            t = $urandom;
            ext_present = ($urandom % 8) != 0;
            ext_enabled = ($urandom % 8) != 0;
            ext_code = codes[i];
            issue = 1;
            if (i == 4) begin
                // Unknown code draws no answer
            end else if (!ext_present) q.push_back({3'h2, last});
            else if (!ext_enabled) q.push_back({3'h4, last});
            else begin
                acc[acc_sel] = f(ext_code, s, t, acc[acc_sel]);
                last = acc[acc_sel];
                q.push_back({3'h1, last});
            end
            @(negedge ref_clk);
        end
        issue = 0;
        for (i = 0; i < 4; i = i + 1) begin
            acc_rd_sel = i[1:0];
            repeat (2) @(negedge ref_clk);
            check({acc_rd_high_r, acc_rd_low_r}, acc[i]);
        end
        check({63'h0, ouflag_r}, {63'h0, fw});
        check(q.size(), 67'h0);
        tally_and_finish;
    end
endmodule
